//--- hw/vmsw_pkg.sv
// shared constants and types for the velocity mode status word block
package vmsw_pkg;
    // status word bit positions
    localparam int unsigned VMSW_BIT_TORQUE_LIMIT = 15;
    localparam int unsigned VMSW_BIT_SPEED_ZERO   = 12;
    localparam int unsigned VMSW_BIT_LIMIT_ACTIVE = 11;
    localparam int unsigned VMSW_BIT_TARGET_REACH = 10;
    localparam int unsigned VMSW_BIT_REMOTE       = 9;
    localparam int unsigned VMSW_BIT_WARNING      = 7;
    localparam int unsigned VMSW_STATE_MSB        = 6;

    // controlword bit positions
    localparam int unsigned VMSW_CW_HALT          = 8;
    localparam int unsigned VMSW_CW_TYPE_LO       = 12;
    localparam int unsigned VMSW_CW_TYPE_HI       = 13;
    localparam int unsigned VMSW_CW_ENABLE_OP     = 3;

    // widths
    localparam int unsigned VMSW_SPEED_W          = 32;
    localparam int unsigned VMSW_SYNC_STAGES      = 2;

    // values after reset
    localparam logic [15:0] VMSW_STATUS_RST       = 16'h0000;
    localparam logic [31:0] VMSW_SPEED_RST        = 32'h0000_0000;

    // speed-attained judgment modes
    localparam logic        VMSW_VA_WINDOW        = 1'b0;
    localparam logic        VMSW_VA_AT_OR_ABOVE   = 1'b1;

    typedef enum logic [1:0] {
        VMSW_OP_POSITION = 2'h0,
        VMSW_OP_SPEED    = 2'h1,
        VMSW_OP_PUSH     = 2'h2,
        VMSW_OP_TORQUE   = 2'h3
    } vmsw_op_e;
endpackage

//--- hw/vmsw_sync.sv
// multi-bit two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module vmsw_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule // vmsw_sync

//--- hw/vmsw_status.sv
// profile velocity mode status word builder and operation type decoder
// How it works
// - bit 15 follows the torque-upper-limit-reached input.
// - bit 12 is 1 exactly when the internal speed command is zero.
// - bit 11 is the OR of limit sensors, prohibit inputs, software and mechanical limits.
// - halt clear: bit 10 mirrors the speed-attained output from the configured judgment.
// - halt set: bit 10 is 1 only once the speed command reaches zero.
// - bit 9 shows that initialization has completed.
// - bit 7 follows information presence and drops by itself when causes clear.
// - torque-control type with halt clear starts directly at target velocity, bypassing the ramp.
// - controlword bit 8 halts operation via the configured halt option.
// - controlword bits 13:12 select operation type, effective immediately.
`timescale 1ns/1ns
module vmsw_status
    import vmsw_pkg::*;
(
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_rst,
    input  wire logic [15:0]                          i_controlword,
    input  wire logic [vmsw_pkg::VMSW_STATE_MSB:0]    i_drive_state,
    input  wire logic                                 i_torque_limit_reached,
    input  wire logic signed [vmsw_pkg::VMSW_SPEED_W-1:0] i_speed_cmd,
    input  wire logic signed [vmsw_pkg::VMSW_SPEED_W-1:0] i_feedback_speed,
    input  wire logic signed [vmsw_pkg::VMSW_SPEED_W-1:0] i_target_velocity,
    input  wire logic signed [vmsw_pkg::VMSW_SPEED_W-1:0] i_profile_speed,
    input  wire logic                                 i_va_mode,
    input  wire logic [vmsw_pkg::VMSW_SPEED_W-1:0]    i_va_range,
    input  wire logic [1:0]                           i_travel_limit_sensor_inputs,
    input  wire logic [1:0]                           i_direction_prohibit_inputs,
    input  wire logic                                 i_soft_limit,
    input  wire logic                                 i_mech_limit,
    input  wire logic                                 i_init_done,
    input  wire logic                                 i_info_present,
    output logic [15:0]                               o_status_word,
    output logic                                      o_speed_attained_output,
    output vmsw_pkg::vmsw_op_e                        o_op_type,
    output logic                                      o_halt_request,
    output logic                                      o_ramp_bypass,
    output logic                                      o_direct_start,
    output logic signed [vmsw_pkg::VMSW_SPEED_W-1:0]  o_velocity_ref
);
    import vmsw_pkg::*;

    localparam int unsigned EXT_W = VMSW_SPEED_W + 2;

    // pins arrive unsynchronised; each pin group gets its own two-stage crossing
    logic [1:0] sensor_sync;
    logic [1:0] prohibit_sync;

    vmsw_sync #(
        .WIDTH (2)
    ) u_sensor_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (i_travel_limit_sensor_inputs),
        .o_sync  (sensor_sync)
    );

    vmsw_sync #(
        .WIDTH (2)
    ) u_prohibit_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (i_direction_prohibit_inputs),
        .o_sync  (prohibit_sync)
    );

    logic [15:0]                    status_word;
    logic [15:0]                    next_status_word;
    logic                           speed_attained;
    logic                           next_speed_attained;
    logic                           torque_armed;
    logic                           next_torque_armed;
    logic                           direct_start;
    logic                           next_direct_start;
    logic signed [VMSW_SPEED_W-1:0] velocity_ref;
    logic signed [VMSW_SPEED_W-1:0] next_velocity_ref;

    vmsw_op_e                       op_type;
    logic                           halt;
    logic                           torque_mode;
    logic                           speed_zero;
    logic                           limit_active;
    logic                           va_judge;
    logic signed [EXT_W-1:0]        err;
    logic [EXT_W-1:0]               abs_err;
    logic [EXT_W-1:0]               abs_fb;
    logic [EXT_W-1:0]               abs_tgt;
    logic [EXT_W-1:0]               range_ext;
    logic                           sensor_limit;
    logic                           prohibit_limit;
    logic                           target_reached;

    // controlword decode is combinational so a type change acts at once
    always_comb begin
        op_type     = vmsw_op_e'(i_controlword[VMSW_CW_TYPE_HI:VMSW_CW_TYPE_LO]);
        halt        = i_controlword[VMSW_CW_HALT];
        case (op_type)
            VMSW_OP_TORQUE: begin
                torque_mode = 1'b1;
            end
            default: begin
                torque_mode = 1'b0;
            end
        endcase
    end

    // speed-attained judgment; wide arithmetic avoids overflow at full-scale speeds
    always_comb begin
        err       = EXT_W'(i_feedback_speed) - EXT_W'(i_target_velocity);
        abs_err   = err[EXT_W-1] ? EXT_W'(-err) : EXT_W'(err);
        abs_fb    = i_feedback_speed[VMSW_SPEED_W-1] ? EXT_W'(-EXT_W'(i_feedback_speed))
                                                       : EXT_W'(i_feedback_speed);
        abs_tgt   = i_target_velocity[VMSW_SPEED_W-1] ? EXT_W'(-EXT_W'(i_target_velocity))
                                                        : EXT_W'(i_target_velocity);
        range_ext = EXT_W'(i_va_range);
    end

    // mode is static configuration; the window form compares the error magnitude
    always_comb begin
        case (i_va_mode)
            VMSW_VA_WINDOW: begin
                va_judge = (abs_err <= range_ext);
            end
            VMSW_VA_AT_OR_ABOVE: begin
                va_judge = (abs_fb + range_ext >= abs_tgt);
            end
            default: begin
                va_judge = 1'b0;
            end
        endcase
    end

    // during halt the bit reports stop completion rather than speed match
    always_comb begin
        if (halt) begin
            target_reached = (i_speed_cmd == '0);
        end else begin
            target_reached = va_judge;
        end
    end

    always_comb begin
        speed_zero     = (i_speed_cmd == '0);
        // limits are combined only after the crossing so no raw pin reaches bit 11
        sensor_limit   = |sensor_sync;
        prohibit_limit = |prohibit_sync;
        limit_active   = sensor_limit | prohibit_limit | i_soft_limit | i_mech_limit;

        next_speed_attained = va_judge;

        next_status_word                        = VMSW_STATUS_RST;
        next_status_word[VMSW_STATE_MSB:0]      = i_drive_state;
        next_status_word[VMSW_BIT_TORQUE_LIMIT] = i_torque_limit_reached;
        next_status_word[VMSW_BIT_SPEED_ZERO]   = speed_zero;
        next_status_word[VMSW_BIT_LIMIT_ACTIVE] = limit_active;
        next_status_word[VMSW_BIT_TARGET_REACH] = target_reached;
        next_status_word[VMSW_BIT_REMOTE]       = i_init_done;
        // level follow, no latch: clears itself once the causes are gone
        next_status_word[VMSW_BIT_WARNING]      = i_info_present;
    end

    // a torque start is edge-detected so the pulse fires once per entry
    always_comb begin
        next_torque_armed = torque_mode & ~halt & i_controlword[VMSW_CW_ENABLE_OP];
        next_direct_start = next_torque_armed & ~torque_armed;
    end

    // torque control without halt skips the profile ramp; halt and other types take the ramped speed
    always_comb begin
        if (halt) begin
            next_velocity_ref = i_profile_speed;
        end else if (torque_mode) begin
            next_velocity_ref = i_target_velocity;
        end else begin
            next_velocity_ref = i_profile_speed;
        end
    end

    // status word and speed-attained share one stage so both answer in one cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            status_word    <= VMSW_STATUS_RST;
            speed_attained <= 1'b0;
        end else begin
            status_word    <= next_status_word;
            speed_attained <= next_speed_attained;
        end
    end

    // armed state remembers the previous cycle for the start edge detect
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            torque_armed <= 1'b0;
            direct_start <= 1'b0;
        end else begin
            torque_armed <= next_torque_armed;
            direct_start <= next_direct_start;
        end
    end

    // registered so the motion side never sees a decode glitch
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            velocity_ref <= VMSW_SPEED_RST;
        end else begin
            velocity_ref <= next_velocity_ref;
        end
    end

    always_comb begin
        o_status_word           = status_word;
        o_speed_attained_output = speed_attained;
        o_op_type               = op_type;
        o_halt_request          = halt;
        // halt hands deceleration back to the ramp even in torque control
        o_ramp_bypass           = torque_mode & ~halt;
        o_direct_start          = direct_start;
        o_velocity_ref          = velocity_ref;
    end
endmodule // vmsw_status

//--- dv/vmsw_master.sv
// fieldbus controller model that writes the controlword
`timescale 1ns/1ns
module vmsw_master (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_cw_req,
    output logic      [15:0] o_controlword
);
    initial o_controlword = 16'h0000;
    // writes land off the sampling edge, so halt and type reach the drive whole
    always @(negedge i_mclk) o_controlword <= i_cw_req;
endmodule // vmsw_master

//--- dv/vmsw_status_sva.sv
// checker for the velocity mode status word block
`timescale 1ns/1ns
module vmsw_status_sva
    import vmsw_pkg::*;
(
    input wire logic               i_mclk,
    input wire logic               i_rst,
    input wire logic        [15:0] i_controlword,
    input wire logic        [6:0]  i_drive_state,
    input wire logic               i_torque_limit_reached,
    input wire logic signed [31:0] i_speed_cmd,
    input wire logic signed [31:0] i_feedback_speed,
    input wire logic signed [31:0] i_target_velocity,
    input wire logic               i_va_mode,
    input wire logic        [1:0]  i_travel_limit_sensor_inputs,
    input wire logic               i_init_done,
    input wire logic               i_info_present,
    input wire logic        [15:0] o_status_word,
    input wire logic               o_speed_attained_output,
    input wire vmsw_op_e           o_op_type,
    input wire logic               o_halt_request,
    input wire logic               o_ramp_bypass,
    input wire logic               o_direct_start,
    input wire logic signed [31:0] o_velocity_ref
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // pins pass two sync stages before the output register
    sequence s_pin_held; (|i_travel_limit_sensor_inputs) [*3]; endsequence
    sequence s_pulse; o_direct_start ##1 !o_direct_start; endsequence
    property p_tlc; 1 |=> o_status_word[15] == $past(i_torque_limit_reached); endproperty
    property p_zero; 1 |=> o_status_word[12] == ($past(i_speed_cmd) == 0); endproperty
    property p_pins; s_pin_held |=> o_status_word[11]; endproperty
    property p_va; !i_controlword[8] && !i_va_mode && i_feedback_speed == i_target_velocity |=> o_status_word[10];
    endproperty
    property p_halt; i_controlword[8] |=> o_status_word[10] == ($past(i_speed_cmd) == 0); endproperty
    property p_flags; 1 |=> o_status_word[9] == $past(i_init_done) && o_status_word[7] == $past(i_info_present);
    endproperty
    property p_direct; $rose(i_controlword[13:12] == 2'h3 && !i_controlword[8] && i_controlword[3])
        |=> o_velocity_ref == $past(i_target_velocity) ##0 s_pulse; endproperty
    property p_decode; o_op_type == i_controlword[13:12] && o_halt_request == i_controlword[8]
        && o_ramp_bypass == (i_controlword[13:12] == 2'h3 && !i_controlword[8]); endproperty
    property p_state; 1 |=> o_status_word[6:0] == $past(i_drive_state) && o_status_word[14:13] == 2'h0
        && !o_status_word[8]; endproperty
    a_tlc: assert property (p_tlc) else $error("torque limit bit wrong");
    a_zero: assert property (p_zero) else $error("speed zero bit wrong");
    a_pins: assert property (p_pins) else $error("limit bit missed pin");
    a_va: assert property (p_va) else $error("target reached missed");
    a_halt: assert property (p_halt) else $error("halt target bit wrong");
    a_flags: assert property (p_flags) else $error("remote or warning bit wrong");
    a_direct: assert property (p_direct) else $error("direct start wrong");
    a_decode: assert property (p_decode) else $error("controlword decode wrong");
    a_state: assert property (p_state) else $error("state bits wrong");
    property p_attain; !i_va_mode && i_feedback_speed == i_target_velocity |=> o_speed_attained_output; endproperty
    a_attain: assert property (p_attain) else $error("speed attained missed");
endmodule // vmsw_status_sva

//--- dv/vmsw_status_bench.sv
// self-checking random bench for the velocity mode status word block
`timescale 1ns/1ns
module vmsw_status_bench;
    import vmsw_pkg::*;
    logic i_mclk, i_rst, i_torque_limit_reached, i_va_mode, i_soft_limit, i_mech_limit, i_init_done;
    logic i_info_present, o_speed_attained_output, o_halt_request, o_ramp_bypass, o_direct_start, c_prev;
    logic        [15:0] i_controlword, cw_req, o_status_word;
    logic        [6:0]  i_drive_state;
    logic        [1:0]  i_travel_limit_sensor_inputs, i_direction_prohibit_inputs, h;
    logic        [31:0] i_va_range;
    logic signed [31:0] i_speed_cmd, i_feedback_speed, i_target_velocity, i_profile_speed, o_velocity_ref;
    vmsw_op_e           o_op_type;
    int                 n_fail, n_checks, cyc;
    vmsw_master u_vmsw_master (.i_mclk(i_mclk), .i_cw_req(cw_req), .o_controlword(i_controlword));
    vmsw_status u_vmsw_status (.*);
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            complete_run;
        end
    end
    task automatic complete_run;
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // small speeds and ranges so equality and range edges come up often
    function automatic int rs();
        return int'($urandom_range(12)) - 6;
    endfunction
    function automatic logic exp_va();
        longint f, t, d;
        f = i_feedback_speed;
        t = i_target_velocity;
        d = f > t ? f - t : t - f;
        return i_va_mode ? (f < 0 ? -f : f) + i_va_range >= (t < 0 ? -t : t) : d <= i_va_range;
    endfunction
    function automatic logic [15:0] exp_sw(logic lim);
        return {i_torque_limit_reached, 2'h0, i_speed_cmd == 0, lim,
                i_controlword[8] ? i_speed_cmd == 0 : exp_va(),
                i_init_done, 1'b0, i_info_present, i_drive_state};
    endfunction
    // k selects a full-scale corner (1, 2) or random small values (0)
    task automatic drive(int k);
        cw_req <= 16'($urandom);
        i_drive_state <= 7'($urandom);
        {i_torque_limit_reached, i_va_mode, i_init_done, i_info_present} <= 4'($urandom);
        {i_soft_limit, i_mech_limit} <= $urandom_range(7) == 0 ? 2'($urandom) : 2'h0;
        i_speed_cmd <= rs();
        i_feedback_speed <= k == 1 ? 32'sh8000_0000 : k == 2 ? 32'sh7fff_ffff : rs();
        i_target_velocity <= k == 1 ? 32'sh7fff_ffff : k == 2 ? 32'sh8000_0000 : rs();
        i_profile_speed <= rs();
        i_va_range <= k == 1 ? 32'hffff_ffff : k == 2 ? 32'hffff_fffe : $urandom_range(4);
        if ($urandom_range(5) == 0) {i_travel_limit_sensor_inputs, i_direction_prohibit_inputs} <= 4'(1 << $urandom_range(4));
    endtask
    task automatic do_reset;
        @(negedge i_mclk);
        i_rst <= 1'b1;
        {i_travel_limit_sensor_inputs, i_direction_prohibit_inputs} <= 4'h0;
        h = 2'h0;
        c_prev = 1'b0;
        repeat (10) @(negedge i_mclk);
        chk(o_status_word, 16'h0000);
        chk(o_velocity_ref, 32'h0000_0000);
        chk({o_speed_attained_output, o_direct_start}, 32'h0000_0000);
        i_rst <= 1'b0;
    endtask
    // checks read the values sampled at the last edge, before new stimulus lands
    task automatic step(int k);
        logic tq;
        @(negedge i_mclk);
        tq = i_controlword[13:12] == 2'h3 && !i_controlword[8];
        chk(o_status_word, exp_sw(h[1] | i_soft_limit | i_mech_limit));
        chk(o_op_type, i_controlword[13:12]);
        chk(o_halt_request, i_controlword[8]);
        chk({o_ramp_bypass, o_direct_start}, {tq, tq && i_controlword[3] && !c_prev});
        chk(o_velocity_ref, tq ? i_target_velocity : i_profile_speed);
        chk(o_speed_attained_output, exp_va());
        c_prev = tq && i_controlword[3];
        h = {h[0], |{i_travel_limit_sensor_inputs, i_direction_prohibit_inputs}};
        drive(k);
    endtask
    initial begin
        void'($urandom(44953));
        i_rst = 1'b1;
        drive(0);
        repeat (2) begin
            do_reset;
            repeat (2) step(1);
            repeat (2) step(2);
            repeat (400) step(0);
        end
        complete_run;
    end
endmodule // vmsw_status_bench
bind vmsw_status vmsw_status_sva u_vmsw_status_sva (.*);
